// ---- hdl/multiqueue_almost_flags_powerdown.sv ----
`timescale 1ns/1ps
`default_nettype none

module multiqueue_almost_flags_powerdown (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    // Write port (controller logic, same clock)
    input  wire logic [4:0]  write_queue_address,
    input  wire logic        write_address_enable,
    input  wire logic        write_enable,
    // Read port (controller logic, same clock)
    input  wire logic [4:0]  read_queue_address,
    input  wire logic        read_address_enable,
    input  wire logic        read_enable,
    // Power-down pin, asynchronous
    input  wire logic        power_down_n,
    // Flags
    output logic             active_almost_full_flag_n,
    output logic             active_almost_empty_flag_n,
    output logic      [7:0]  almost_full_status_bus_n,
    output logic      [7:0]  almost_empty_status_bus_n,
    output logic             power_down_active,
    output logic             resume_ready,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);

    typedef struct packed {
        logic [4:0]                wq;
        logic [4:0]                rq;
        logic [4:0]                wq_tag;
        logic [4:0]                rq_tag;
        logic [4:0]                wq_out;
        logic [4:0]                rq_out;
        logic [31:0][10:0]         count;
        logic [31:0]               af_vec;
        logic [31:0]               ae_vec;
        logic                      af_n;
        logic                      ae_n;
        logic [7:0]                af_bus_n;
        logic [7:0]                ae_bus_n;
        logic                      pd_meta;
        logic                      pd_sync;
        logic [3:0]                wake_cnt;
        logic                      ready;
        mq_flags_pkg::bus_phase_t  phase;
        logic [31:0]               rdata;
        logic                      default_sel;
        mq_flags_pkg::load_state_t load;
        logic [4:0]                load_idx;
    } state_t;

    state_t      s;
    state_t      nxt_s;

    logic        ram_wr_en;
    logic [4:0]  ram_wr_addr;
    logic [21:0] ram_wr_data;
    logic [21:0] ofs_a;
    logic [21:0] ofs_b;
    logic [21:0] ofs_c;
    logic        bus_req;
    logic        hit_table;
    logic        loading;
    logic        running;
    logic [10:0] def_ofs;
    logic [31:0] table_word;
    logic [31:0] merged;

    // ------------------------------------------------------------
    // Offset storage: port a follows write queue, b read queue, c bus
    // ------------------------------------------------------------
    offset_ram u_offset_ram (
        .clk       (clk),
        .en        (ce),
        .wr_en     (ram_wr_en),
        .wr_addr   (ram_wr_addr),
        .wr_data   (ram_wr_data),
        .rd_addr_a (s.wq),
        .rd_addr_b (s.rq),
        .rd_addr_c (avs_address[6:2]),
        .rd_data_a (ofs_a),
        .rd_data_b (ofs_b),
        .rd_data_c (ofs_c)
    );

    // ------------------------------------------------------------
    // Bus decode and offset word merge
    // ------------------------------------------------------------
    assign bus_req    = avs_read | avs_write;
    assign hit_table  = avs_address <= mq_flags_pkg::OFS_TABLE_LAST;
    assign loading    = s.load == mq_flags_pkg::LOAD_RUN;
    assign running    = ce & s.pd_sync;
    assign def_ofs    = s.default_sel ? mq_flags_pkg::DEF_OFS_HI
                                      : mq_flags_pkg::DEF_OFS_LO;
    assign table_word = {5'h00, ofs_c[21:11], 5'h00, ofs_c[10:0]};

    // Byte lanes of a partial write keep the stored bytes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            merged[i*8 +: 8] = avs_byteenable[i] ? avs_writedata[i*8 +: 8]
                                                 : table_word[i*8 +: 8];
        end
    end

    // Loader writes defaults; otherwise the bus writes a table word
    always_comb begin
        if (loading) begin
            ram_wr_en   = running;
            ram_wr_addr = s.load_idx;
            ram_wr_data = {def_ofs, def_ofs};
        end else begin
            ram_wr_en   = running & avs_write & hit_table
                        & (s.phase == mq_flags_pkg::BUS_DONE);
            ram_wr_addr = avs_address[6:2];
            ram_wr_data = {merged[mq_flags_pkg::FLD_AE_LSB +: mq_flags_pkg::OFFSET_W],
                           merged[mq_flags_pkg::FLD_AF_LSB +: mq_flags_pkg::OFFSET_W]};
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s;
        if (ce) begin
            // Pin synchroniser keeps running so an exit is always seen
            nxt_s.pd_meta = power_down_n;
            nxt_s.pd_sync = s.pd_meta;
            if (!s.pd_sync) begin
                nxt_s.wake_cnt = 4'h0;
                nxt_s.ready    = 1'b0;
            end else if (s.wake_cnt != mq_flags_pkg::WAKE_COUNT) begin
                nxt_s.wake_cnt = s.wake_cnt + 4'h1;
            end else begin
                nxt_s.ready = 1'b1;
            end
        end

        // Power-down freezes everything below; no reset on exit
        if (running) begin
            // Queue selection
            if (write_address_enable) begin
                nxt_s.wq = write_queue_address;
            end
            if (read_address_enable) begin
                nxt_s.rq = read_queue_address;
            end
            nxt_s.wq_tag = s.wq;
            nxt_s.rq_tag = s.rq;
            // Flags and buses follow the tag one edge later: the old queue
            // stays on them until the third edge after a switch
            nxt_s.wq_out = s.wq_tag;
            nxt_s.rq_out = s.rq_tag;

            // Fill counts of the active queues
            if (write_enable && s.count[s.wq] != mq_flags_pkg::QUEUE_DEPTH) begin
                nxt_s.count[s.wq] = s.count[s.wq] + 11'h001;
            end
            if (read_enable && s.count[s.rq] != 11'h000) begin
                nxt_s.count[s.rq] = nxt_s.count[s.rq] - 11'h001;
            end

            // Per-queue flags; the offset ports hold the tagged queues, so the
            // queue just left still sees a transfer made on the switch edge
            if (!loading) begin
                nxt_s.af_vec[s.wq_tag] = mq_flags_pkg::almost_full(s.count[s.wq_tag],
                                                                   ofs_a[10:0]);
                nxt_s.ae_vec[s.wq_tag] = mq_flags_pkg::almost_empty(s.count[s.wq_tag],
                                                                    ofs_a[21:11]);
                nxt_s.af_vec[s.rq_tag] = mq_flags_pkg::almost_full(s.count[s.rq_tag],
                                                                   ofs_b[10:0]);
                nxt_s.ae_vec[s.rq_tag] = mq_flags_pkg::almost_empty(s.count[s.rq_tag],
                                                                    ofs_b[21:11]);
            end

            // Output stage: active queue flags, active low
            nxt_s.af_n     = ~s.af_vec[s.wq_out];
            nxt_s.ae_n     = ~s.ae_vec[s.rq_out];
            nxt_s.af_bus_n = ~s.af_vec[{s.wq_out[4:3], 3'b000} +: 8];
            nxt_s.ae_bus_n = ~s.ae_vec[{s.rq_out[4:3], 3'b000} +: 8];

            // Default offset loader
            if (loading) begin
                nxt_s.load_idx = s.load_idx + 5'h01;
                if (s.load_idx == 5'h1F) begin
                    nxt_s.load = mq_flags_pkg::LOAD_IDLE;
                end
            end

            // Bus slave: fetch, then answer on the third edge
            unique case (s.phase)
                mq_flags_pkg::BUS_IDLE: begin
                    if (bus_req && !loading) begin
                        nxt_s.phase = mq_flags_pkg::BUS_FETCH;
                    end
                end
                mq_flags_pkg::BUS_FETCH: begin
                    nxt_s.phase = mq_flags_pkg::BUS_DONE;
                    nxt_s.rdata = 32'h0000_0000;
                    if (avs_read) begin
                        if (hit_table) begin
                            nxt_s.rdata = table_word;
                        end else if (avs_address == mq_flags_pkg::REG_AF_VECTOR) begin
                            nxt_s.rdata = s.af_vec;
                        end else if (avs_address == mq_flags_pkg::REG_AE_VECTOR) begin
                            nxt_s.rdata = s.ae_vec;
                        end else if (avs_address == mq_flags_pkg::REG_CONTROL) begin
                            nxt_s.rdata[mq_flags_pkg::CTRL_DEFSEL_BIT] = s.default_sel;
                        end else if (avs_address == mq_flags_pkg::REG_STATUS) begin
                            nxt_s.rdata[mq_flags_pkg::STAT_WQ_LSB +: 5]  = s.wq;
                            nxt_s.rdata[mq_flags_pkg::STAT_RQ_LSB +: 5]  = s.rq;
                            nxt_s.rdata[mq_flags_pkg::STAT_PD_BIT]    = ~s.pd_sync;
                            nxt_s.rdata[mq_flags_pkg::STAT_READY_BIT] = s.ready;
                            nxt_s.rdata[mq_flags_pkg::STAT_BUSY_BIT]  = loading;
                        end
                    end
                end
                mq_flags_pkg::BUS_DONE: begin
                    nxt_s.phase = mq_flags_pkg::BUS_IDLE;
                    if (avs_write && avs_address == mq_flags_pkg::REG_CONTROL
                        && avs_byteenable[0]) begin
                        nxt_s.default_sel = avs_writedata[mq_flags_pkg::CTRL_DEFSEL_BIT];
                        if (avs_writedata[mq_flags_pkg::CTRL_LOAD_BIT]) begin
                            nxt_s.load     = mq_flags_pkg::LOAD_RUN;
                            nxt_s.load_idx = 5'h00;
                        end
                    end
                end
            endcase
        end

        if (srst) begin
            nxt_s          = '0;
            nxt_s.ae_vec   = 32'hFFFF_FFFF;
            nxt_s.af_n     = 1'b1;
            nxt_s.af_bus_n = 8'hFF;
            nxt_s.pd_meta  = 1'b1;
            nxt_s.pd_sync  = 1'b1;
            nxt_s.ready    = 1'b1;
            nxt_s.wake_cnt = mq_flags_pkg::WAKE_COUNT;
            nxt_s.phase    = mq_flags_pkg::BUS_IDLE;
            nxt_s.load     = mq_flags_pkg::LOAD_RUN;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        s <= nxt_s;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign active_almost_full_flag_n  = s.af_n;
    assign active_almost_empty_flag_n = s.ae_n;
    assign almost_full_status_bus_n   = s.af_bus_n;
    assign almost_empty_status_bus_n  = s.ae_bus_n;
    assign power_down_active          = ~s.pd_sync;
    assign resume_ready               = s.ready;
    assign avs_readdata               = s.rdata;
    assign avs_waitrequest            = bus_req & (s.phase != mq_flags_pkg::BUS_DONE);

endmodule : multiqueue_almost_flags_powerdown

`default_nettype wire

// ---- hdl/mq_flags_pkg.sv ----

package mq_flags_pkg;

    // ------------------------------------------------------------
    // Queue geometry
    // ------------------------------------------------------------
    localparam int          QUEUE_COUNT = 32;
    localparam int          QADDR_W     = 5;
    localparam int          COUNT_W     = 11;
    localparam int          OFFSET_W    = 11;
    localparam int          GROUP_W     = 8;
    localparam logic [10:0] QUEUE_DEPTH = 11'h400;
    localparam logic [10:0] DEF_OFS_LO  = 11'h008;
    localparam logic [10:0] DEF_OFS_HI  = 11'h080;
    localparam int          OFSW_W      = 2 * OFFSET_W;

    // ------------------------------------------------------------
    // Register map (byte addresses) and field positions
    // ------------------------------------------------------------
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 32;
    localparam logic [7:0] OFS_TABLE_LAST  = 8'h7C;
    localparam logic [7:0] REG_AF_VECTOR   = 8'h80;
    localparam logic [7:0] REG_AE_VECTOR   = 8'h84;
    localparam logic [7:0] REG_CONTROL     = 8'h88;
    localparam logic [7:0] REG_STATUS      = 8'h8C;
    localparam int         FLD_AF_LSB      = 0;
    localparam int         FLD_AE_LSB      = 16;
    localparam int         CTRL_DEFSEL_BIT = 0;
    localparam int         CTRL_LOAD_BIT   = 1;
    localparam int         STAT_WQ_LSB     = 0;
    localparam int         STAT_RQ_LSB     = 8;
    localparam int         STAT_PD_BIT     = 16;
    localparam int         STAT_READY_BIT  = 17;
    localparam int         STAT_BUSY_BIT   = 18;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 100;
    localparam int         WAKE_TIME_NS  = 1000;
    localparam int         WAKE_CYCLES   = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WAKE_COUNT    = 4'(WAKE_CYCLES);

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_FETCH = 3'b010,
        BUS_DONE  = 3'b100
    } bus_phase_t;

    typedef enum logic [1:0] {
        LOAD_IDLE = 2'b01,
        LOAD_RUN  = 2'b10
    } load_state_t;

    // Almost full once fill reaches depth minus offset
    function automatic logic almost_full(input logic [10:0] cnt, input logic [10:0] ofs);
        almost_full = ({1'b0, cnt} + {1'b0, ofs}) >= {1'b0, QUEUE_DEPTH};
    endfunction : almost_full

    // Almost empty while fill is at or below offset
    function automatic logic almost_empty(input logic [10:0] cnt, input logic [10:0] ofs);
        almost_empty = cnt <= ofs;
    endfunction : almost_empty

endpackage : mq_flags_pkg

// ---- hdl/offset_ram.sv ----
`timescale 1ns/1ps
`default_nettype none

module offset_ram (
    input  wire logic        clk,
    input  wire logic        en,
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_addr,
    input  wire logic [21:0] wr_data,
    input  wire logic [4:0]  rd_addr_a,
    input  wire logic [4:0]  rd_addr_b,
    input  wire logic [4:0]  rd_addr_c,
    output logic      [21:0] rd_data_a,
    output logic      [21:0] rd_data_b,
    output logic      [21:0] rd_data_c
);

    typedef struct packed {
        logic [31:0][21:0] mem;
        logic [21:0]       a;
        logic [21:0]       b;
        logic [21:0]       c;
    } ram_t;

    ram_t s;
    ram_t nxt_s;

    // ------------------------------------------------------------
    // Write port and three registered read ports
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s;
        if (en) begin
            nxt_s.a = s.mem[rd_addr_a];
            nxt_s.b = s.mem[rd_addr_b];
            nxt_s.c = s.mem[rd_addr_c];
            if (wr_en) begin
                nxt_s.mem[wr_addr] = wr_data;
            end
        end
    end

    // Contents carry no reset; the owner reloads defaults after reset
    always_ff @(posedge clk) begin
        s <= nxt_s;
    end

    assign rd_data_a = s.a;
    assign rd_data_b = s.b;
    assign rd_data_c = s.c;

endmodule : offset_ram

`default_nettype wire

// ---- test/mq_flags_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Flag latency and power-down checks
// ----------------
module mq_flags_props (
    input wire logic       clk, srst, write_address_enable, write_enable,
    input wire logic       read_address_enable, read_enable, power_down_n,
    input wire logic       active_almost_full_flag_n, active_almost_empty_flag_n,
    input wire logic [7:0] almost_full_status_bus_n, almost_empty_status_bus_n,
    input wire logic       power_down_active, resume_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Flag edges come from a transfer two edges back or a switch three back
    AST_AF_FALL: assert property ($fell(active_almost_full_flag_n) |->
        $past(write_enable, 3) || $past(write_address_enable, 4)) else $error("af fall");
    AST_AF_RISE: assert property ($rose(active_almost_full_flag_n) |->
        $past(read_enable, 3) || $past(write_address_enable, 4)) else $error("af rise");
    AST_AE_FALL: assert property ($fell(active_almost_empty_flag_n) |->
        $past(read_enable, 3) || $past(read_address_enable, 4)) else $error("ae fall");
    AST_AE_RISE: assert property ($rose(active_almost_empty_flag_n) |->
        $past(write_enable, 3) || $past(read_address_enable, 4)) else $error("ae rise");
    // Power-down entry, hold and exit
    AST_PD_ENTER: assert property ($fell(power_down_n) |->
        ##[1:3] power_down_active) else $error("pd entry");
    AST_PD_STAY: assert property (power_down_active && !power_down_n |=>
        power_down_active) else $error("pd left early");
    AST_PD_EXIT: assert property ($rose(power_down_n) |->
        ##[1:3] !power_down_active) else $error("pd exit");
    AST_PD_HOLD: assert property ($past(power_down_active) |->
        $stable(active_almost_full_flag_n) && $stable(active_almost_empty_flag_n)
        && $stable(almost_full_status_bus_n) && $stable(almost_empty_status_bus_n))
        else $error("flags moved in pd");
    AST_RESUME: assert property ($fell(power_down_active) |->
        !resume_ready [*8] ##[1:6] resume_ready) else $error("resume timing");
    // Main scenarios reached
    CVR_AF_SET: cover property ($fell(active_almost_full_flag_n));
    CVR_AE_CLR: cover property ($rose(active_almost_empty_flag_n));
    CVR_PD_OUT: cover property ($fell(power_down_active));
endmodule : mq_flags_props
`default_nettype wire

// ---- test/queue_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Port controller; its clock keeps running in power-down
// ----------------
module queue_controller (
    input  wire logic       clk,
    output logic      [4:0] write_queue_address,
    output logic            write_address_enable,
    output logic            write_enable,
    output logic      [4:0] read_queue_address,
    output logic            read_address_enable,
    output logic            read_enable,
    output logic            power_down_n
);
    // Idle ports, power-down released
    initial begin
        write_queue_address  = 5'h00;
        write_address_enable = 1'h0;
        write_enable         = 1'h0;
        read_queue_address   = 5'h00;
        read_address_enable  = 1'h0;
        read_enable          = 1'h0;
        power_down_n         = 1'h1;
    end

    // Queue select; a released address shows its inverse
    task automatic sel(input logic rd, input logic [4:0] q);
        @(posedge clk);
        if (rd) begin
            read_queue_address  <= q;
            read_address_enable <= 1'h1;
        end else begin
            write_queue_address  <= q;
            write_address_enable <= 1'h1;
        end
        @(posedge clk);
        read_address_enable  <= 1'h0;
        write_address_enable <= 1'h0;
        read_queue_address   <= ~read_queue_address;
        write_queue_address  <= ~write_queue_address;
    endtask : sel

    // Burst of n reads or writes, one per edge
    task automatic xfer(input logic rd, input int n);
        @(posedge clk);
        read_enable  <= rd;
        write_enable <= !rd;
        repeat (n) @(posedge clk);
        read_enable  <= 1'h0;
        write_enable <= 1'h0;
    endtask : xfer

    // Enter after idle enables, or leave and wait before traffic
    task automatic pd(input logic enter);
        if (enter) begin
            repeat (4) @(posedge clk);
        end
        @(posedge clk);
        power_down_n <= !enter;
        if (!enter) begin
            repeat (mq_flags_pkg::WAKE_CYCLES) @(posedge clk);
        end
    endtask : pd
endmodule : queue_controller
`default_nettype wire

// ---- test/tb_multiqueue_almost_flags_powerdown.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_multiqueue_almost_flags_powerdown;
    // ----------------
    // Wiring and clock
    // ----------------
    localparam int DEPTH = int'(mq_flags_pkg::QUEUE_DEPTH);
    localparam int M3    = 16;  // Almost-full offset of queue 3
    localparam int N3    = 32;  // Almost-empty offset of queue 3
    logic        clk = 1'h0;
    logic        srst, avs_read, avs_write;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata;
    wire  [31:0] avs_readdata;
    wire  [7:0]  almost_full_status_bus_n, almost_empty_status_bus_n;
    wire  [4:0]  write_queue_address, read_queue_address;
    wire         write_address_enable, write_enable, read_address_enable, read_enable;
    wire         power_down_n, active_almost_full_flag_n, active_almost_empty_flag_n;
    wire         power_down_active, resume_ready, avs_waitrequest;
    int          errors;
    int          comparisons;

    always #50 clk = ~clk;

    multiqueue_almost_flags_powerdown u_dut (
        .clk, .srst, .ce(1'h1), .write_queue_address, .write_address_enable, .write_enable,
        .read_queue_address, .read_address_enable, .read_enable, .power_down_n,
        .active_almost_full_flag_n, .active_almost_empty_flag_n, .almost_full_status_bus_n,
        .almost_empty_status_bus_n, .power_down_active, .resume_ready, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
        .avs_waitrequest);
    queue_controller u_ctrl (
        .clk, .write_queue_address, .write_address_enable, .write_enable,
        .read_queue_address, .read_address_enable, .read_enable, .power_down_n);

    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Let n edges pass and look once their updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic af_at(input int n, input logic exp);
        step(n);
        chk("af", active_almost_full_flag_n, exp);
    endtask : af_at

    task automatic ae_at(input int n, input logic exp);
        step(n);
        chk("ae", active_almost_empty_flag_n, exp);
    endtask : ae_at

    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_read  <= 1'h0;
        avs_write <= 1'h0;
    endtask : bus

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // ----------------
    // Tests
    // ----------------
    initial begin
        logic [31:0] d;
        errors        = 0;
        comparisons   = 0;
        srst          = 1'h1;
        avs_read      = 1'h0;
        avs_write     = 1'h0;
        avs_address   = 8'h00;
        avs_writedata = 32'h0;
        repeat (4) @(posedge clk);
        srst <= 1'h0;
        af_at(1, 1'h1);
        ae_at(0, 1'h0);
        chk("af bus", almost_full_status_bus_n, 8'hFF);
        chk("ae bus", almost_empty_status_bus_n, 8'h00);
        // Default and programmed offsets, unmapped place
        bus(1'h0, 8'h7C, 32'h0, d);
        chk("ofs31", d, 32'h0008_0008);
        bus(1'h1, 8'h0C, 32'h0020_0010, d);
        bus(1'h0, 8'h0C, 32'h0, d);
        chk("ofs3", d, 32'h0020_0010);
        bus(1'h0, 8'h90, 32'h0, d);
        chk("unmapped", d, 32'h0);
        // Almost-empty boundary on queue 3, then read switch
        u_ctrl.sel(1'h0, 5'h03);
        u_ctrl.sel(1'h1, 5'h03);
        u_ctrl.xfer(1'h0, N3);
        ae_at(3, 1'h0);
        u_ctrl.xfer(1'h0, 1);
        ae_at(1, 1'h0);
        ae_at(1, 1'h1);
        chk("ae bus", almost_empty_status_bus_n, 8'h08);
        u_ctrl.xfer(1'h1, 1);
        ae_at(1, 1'h1);
        ae_at(1, 1'h0);
        u_ctrl.xfer(1'h0, 1);
        ae_at(3, 1'h1);
        u_ctrl.sel(1'h1, 5'h04);
        ae_at(2, 1'h1);
        ae_at(1, 1'h0);
        u_ctrl.xfer(1'h0, 1);
        ae_at(3, 1'h0);
        chk("ae bus", almost_empty_status_bus_n, 8'h08);
        // Almost-full boundary on queue 3 (34 words held), then write switch
        u_ctrl.xfer(1'h0, DEPTH - M3 - 35);
        af_at(3, 1'h1);
        u_ctrl.xfer(1'h0, 1);
        af_at(1, 1'h1);
        af_at(1, 1'h0);
        chk("af bus", almost_full_status_bus_n, 8'hF7);
        bus(1'h0, 8'h80, 32'h0, d);
        chk("af vec", d, 32'h0000_0008);
        bus(1'h0, 8'h84, 32'h0, d);
        chk("ae vec", d, 32'hFFFF_FFF7);
        u_ctrl.sel(1'h0, 5'h04);
        af_at(2, 1'h0);
        af_at(1, 1'h1);
        u_ctrl.sel(1'h1, 5'h03);
        u_ctrl.xfer(1'h1, 1);
        af_at(3, 1'h1);
        chk("af bus", almost_full_status_bus_n, 8'hFF);
        u_ctrl.sel(1'h0, 5'h03);
        af_at(3, 1'h1);
        bus(1'h0, 8'h8C, 32'h0, d);
        chk("status", d, 32'h0002_0303);
        // Power-down ignores traffic, keeps state, needs no reset
        u_ctrl.pd(1'h1);
        step(3);
        chk("pd", power_down_active, 1'h1);
        u_ctrl.xfer(1'h0, 1);
        u_ctrl.xfer(1'h1, DEPTH);
        af_at(3, 1'h1);
        ae_at(0, 1'h1);
        u_ctrl.pd(1'h0);
        step(1);
        chk("resume", resume_ready, 1'h0);
        step(6);
        chk("resume", resume_ready, 1'h1);
        u_ctrl.xfer(1'h1, DEPTH - M3 - N3 - 2);
        ae_at(3, 1'h1);
        u_ctrl.xfer(1'h1, 1);
        ae_at(2, 1'h0);
        // Default select 128 with a reload of every offset
        bus(1'h1, 8'h88, 32'h3, d);
        bus(1'h0, 8'h0C, 32'h0, d);
        chk("ofs3 def", d, 32'h0080_0080);
        bus(1'h0, 8'h88, 32'h0, d);
        chk("control", d, 32'h1);
        wrap_up();
    end

    // Watchdog well past the run of some 3200 cycles
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        wrap_up();
    end
endmodule : tb_multiqueue_almost_flags_powerdown

bind multiqueue_almost_flags_powerdown mq_flags_props u_props (
    .clk, .srst, .write_address_enable, .write_enable, .read_address_enable, .read_enable,
    .power_down_n, .active_almost_full_flag_n, .active_almost_empty_flag_n,
    .almost_full_status_bus_n, .almost_empty_status_bus_n, .power_down_active, .resume_ready);
`default_nettype wire
